//--- design/usb_ep_consts.svh
// Offsets, field positions, reset values and counts of the endpoint buffering block
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH
`define OFS_EP0_CTRL 8'h00
`define OFS_TX_MAXP 8'h04
`define OFS_TX_CTRL 8'h08
`define OFS_RX_MAXP 8'h0C
`define OFS_RX_CTRL 8'h10
`define OFS_RX_COUNT 8'h14
`define OFS_RX_FIFO_SIZE 8'h18
`define OFS_EVENTS 8'h1C
`define OFS_RX_DBUF_DIS 8'h20
`define PAYLOAD_W 11
`define MULT_LSB 11
`define BIT_RX_RDY 0
`define BIT_RX_FULL 1
`define BIT_RX_AUTO_CLEAR_READY 2
`define BIT_RX_COMBINE 3
`define BIT_TX_RDY 0
`define BIT_TX_SPLIT 1
`define BIT_EP0_DATA_PHASE_END 0
`define BIT_EP0_SETUPEND 1
`define BIT_EP0_STATUS 2
`define BIT_EP0_TRANSMIT_PACKET_READY 3
`define BIT_EP0_OUTDONE 4
`define EP0_FIFO_BYTES 16'h0040
`define RST_DBUF_DIS 1'h1
`define RST_RX_FIFO_SIZE 16'h0040
`define RST_MAXP 16'h0040
`endif

//--- design/usb_ep_pkg.sv
// Types shared by the endpoint buffering block
package usb_ep_pkg;
  typedef enum logic [1:0] {
    HS_NAK = 2'b00,
    HS_ACK = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE = 2'b11
  } handshake_t;
  typedef enum logic [1:0] {
    TOK_OUT = 2'b00,
    TOK_IN = 2'b01,
    TOK_SETUP = 2'b10
  } token_t;
  typedef struct packed {
    logic valid;
    token_t kind;
    logic [1:0] ep;
    logic [10:0] len;
  } usb_req_t;
  typedef struct packed {
    logic valid;
    handshake_t hs;
    logic [10:0] len;
    logic last;
  } usb_rsp_t;
endpackage

//--- design/usb_ep_buffer.sv
// Device endpoint buffering: split, combine, single/double buffering, NAK and STALL
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "usb_ep_consts.svh"
// Behaviour
// - Split transmit block: low 11 bits payload, upper 5 bits multiplier.
// - Receive FIFO size from its register; packet limit from rx max-packet.
// - FIFO below twice max packet means single-packet buffering.
// - Single buffering: packet in sets ready, full and endpoint event.
// - No packets until ready cleared; clearing returns ACK to host.
// - Auto-clear drops ready and full after max-size packet read.
// - Double buffering: first packet sets ready only; second sets full.
// - Clearing ready while full clears full and leaves ready set for the second packet.
// - Double-buffer disable bit resets set; software clears to enable.
// - Combining decodes payload and multiplier; block length in count.
// - Combined ready after all packets or on a short packet.
// - Unprepared endpoint answers IN and non-zero-endpoint OUT with NAK; SETUP and endpoint-0 OUT get ACK and the STALL cases take priority.
// - Event raised on transaction completion or error end.
// - OUT after data end with OUT data unloaded gets STALL.
// - IN after transmit ready cleared and data end set gets STALL.
// - OUT packet larger than rx max packet gets STALL.
// - Non-zero OUT status packet gets STALL.
// - Early zero-length OUT flushes endpoint-0 IN data, sets setup end.
// - Software sets transmit ready; device clears it after send, event.
// - Endpoint 0 uses the first 64 bytes as one shared buffer.
module usb_ep_buffer
  import usb_ep_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Token requests from the bus engine
  input wire usb_req_t REQ,
  output usb_rsp_t RSP,
  // Receive FIFO unload by software side
  input wire logic RX_POP,
  // Endpoint-0 IN FIFO flush and events
  output logic EP0_FLUSH,
  output logic [2:0] EP_EVENT
);
  logic [15:0] tx_maxp_r, tx_maxp_nxt, rx_maxp_r, rx_maxp_nxt, rx_fifo_r, rx_fifo_nxt;
  logic tx_rdy_r, tx_rdy_nxt, tx_split_r, tx_split_nxt;
  logic [4:0] tx_pkt_r, tx_pkt_nxt;
  logic rx_rdy_r, rx_rdy_nxt, rx_full_r, rx_full_nxt, auto_clear_ready_r, auto_clear_ready_nxt;
  logic comb_r, comb_nxt, dbuf_dis_r, dbuf_dis_nxt;
  logic [15:0] rx_cnt_r, rx_cnt_nxt, rx_cnt2_r, rx_cnt2_nxt, comb_len_r, comb_len_nxt;
  logic [4:0] comb_pkt_r, comb_pkt_nxt;
  logic data_phase_end_r, data_phase_end_nxt, setupend_r, setupend_nxt, status_r, status_nxt;
  logic ep0_transmit_packet_ready_r, ep0_transmit_packet_ready_nxt, outdone_r, outdone_nxt;
  logic [2:0] ev_r, ev_nxt;
  usb_rsp_t rsp_r, rsp_nxt;
  logic flush_r, flush_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [2:0] rdy_r, rdy_nxt;
  logic [3:0] ws_r, ws_nxt, ws_eff;

  function automatic logic [10:0] payload(input logic [15:0] m);
    payload = m[`PAYLOAD_W-1:0];
  endfunction
  function automatic logic [4:0] mult(input logic [15:0] m);
    mult = (m[15:`MULT_LSB] == 5'h00) ? 5'h01 : m[15:`MULT_LSB];
  endfunction
  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = (a == `OFS_EP0_CTRL) || (a == `OFS_TX_MAXP) || (a == `OFS_TX_CTRL) ||
      (a == `OFS_RX_MAXP) || (a == `OFS_RX_CTRL) || (a == `OFS_RX_COUNT) ||
      (a == `OFS_RX_FIFO_SIZE) || (a == `OFS_EVENTS) || (a == `OFS_RX_DBUF_DIS);
  endfunction

  logic dbl, wr_go, rx_clr_sw, tx_set_sw;
  logic [31:0] wd_eff;
  always_comb begin
    dbl = !dbuf_dis_r && (rx_fifo_r >= {rx_maxp_r[14:0], 1'b0}) && !comb_r;
    wd_eff = w_r ? wd_r : WDATA;
    ws_eff = w_r ? ws_r : WSTRB;
    wr_go = (aw_r || AWVALID) && (w_r || WVALID) && !bv_r;
  end

  // Bus slave and register reads
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rresp_nxt = rresp_r;
    if (AWVALID && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = AWADDR;
    end
    if (WVALID && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = WDATA;
      ws_nxt = WSTRB;
    end
    if (aw_nxt && w_nxt && !bv_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = known(aw_r ? awa_r : AWADDR) ? 2'b00 : 2'b10;
    end
    if (bv_r && BREADY)
      bv_nxt = 1'b0;
    if (ARVALID && !rv_r) begin
      rv_nxt = 1'b1;
      rresp_nxt = known(ARADDR) ? 2'b00 : 2'b10;
      unique case (ARADDR)
        `OFS_EP0_CTRL: rd_nxt = {27'h0, outdone_r, ep0_transmit_packet_ready_r, status_r, setupend_r,
          data_phase_end_r};
        `OFS_TX_MAXP: rd_nxt = {16'h0, tx_maxp_r};
        `OFS_TX_CTRL: rd_nxt = {25'h0, tx_pkt_r, tx_split_r, tx_rdy_r};
        `OFS_RX_MAXP: rd_nxt = {16'h0, rx_maxp_r};
        `OFS_RX_CTRL: rd_nxt = {28'h0, comb_r, auto_clear_ready_r, rx_full_r, rx_rdy_r};
        `OFS_RX_COUNT: rd_nxt = {16'h0, rx_cnt_r};
        `OFS_RX_FIFO_SIZE: rd_nxt = {16'h0, rx_fifo_r};
        `OFS_EVENTS: rd_nxt = {29'h0, ev_r};
        `OFS_RX_DBUF_DIS: rd_nxt = {31'h0, dbuf_dis_r};
        default: rd_nxt = 32'h0;
      endcase
    end else if (rv_r && RREADY)
      rv_nxt = 1'b0;
    rdy_nxt = {!aw_nxt && !bv_nxt, !w_nxt && !bv_nxt, !rv_nxt};
  end

  logic [ADDR_W-1:0] wa;
  always_comb begin
    wa = aw_r ? awa_r : AWADDR;
    rx_clr_sw = wr_go && wa == `OFS_RX_CTRL && ws_eff[0] && !wd_eff[`BIT_RX_RDY];
    tx_set_sw = wr_go && wa == `OFS_TX_CTRL && ws_eff[0] && wd_eff[`BIT_TX_RDY];
  end

  // Endpoint state
  always_comb begin
    tx_maxp_nxt = tx_maxp_r;
    rx_maxp_nxt = rx_maxp_r;
    rx_fifo_nxt = rx_fifo_r;
    tx_rdy_nxt = tx_rdy_r;
    tx_split_nxt = tx_split_r;
    tx_pkt_nxt = tx_pkt_r;
    rx_rdy_nxt = rx_rdy_r;
    rx_full_nxt = rx_full_r;
    auto_clear_ready_nxt = auto_clear_ready_r;
    comb_nxt = comb_r;
    dbuf_dis_nxt = dbuf_dis_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_cnt2_nxt = rx_cnt2_r;
    comb_len_nxt = comb_len_r;
    comb_pkt_nxt = comb_pkt_r;
    data_phase_end_nxt = data_phase_end_r;
    setupend_nxt = setupend_r;
    status_nxt = status_r;
    ep0_transmit_packet_ready_nxt = ep0_transmit_packet_ready_r;
    outdone_nxt = outdone_r;
    ev_nxt = ev_r;
    rsp_nxt = '{valid: 1'b0, hs: HS_NONE, len: 11'h000, last: 1'b0};
    flush_nxt = 1'b0;
    if (wr_go && ws_eff[1:0] == 2'b11) begin
      unique case (wa)
        `OFS_TX_MAXP: tx_maxp_nxt = wd_eff[15:0];
        `OFS_RX_MAXP: rx_maxp_nxt = wd_eff[15:0];
        `OFS_RX_FIFO_SIZE: rx_fifo_nxt = wd_eff[15:0];
        default: ;
      endcase
    end
    if (wr_go && ws_eff[0]) begin
      unique case (wa)
        `OFS_EP0_CTRL: begin
          data_phase_end_nxt = wd_eff[`BIT_EP0_DATA_PHASE_END];
          status_nxt = wd_eff[`BIT_EP0_STATUS];
          ep0_transmit_packet_ready_nxt = wd_eff[`BIT_EP0_TRANSMIT_PACKET_READY];
          if (!wd_eff[`BIT_EP0_SETUPEND])
            setupend_nxt = 1'b0;
          if (!wd_eff[`BIT_EP0_OUTDONE])
            outdone_nxt = 1'b0;
        end
        `OFS_TX_CTRL: begin
          tx_split_nxt = wd_eff[`BIT_TX_SPLIT];
          if (tx_set_sw) begin
            tx_rdy_nxt = 1'b1;
            tx_pkt_nxt = 5'h00;
          end
        end
        `OFS_RX_CTRL: begin
          auto_clear_ready_nxt = wd_eff[`BIT_RX_AUTO_CLEAR_READY];
          comb_nxt = wd_eff[`BIT_RX_COMBINE];
        end
        `OFS_EVENTS: ev_nxt = ev_r & ~wd_eff[2:0];
        `OFS_RX_DBUF_DIS: dbuf_dis_nxt = wd_eff[0];
        default: ;
      endcase
    end
    // Unload: software clear, or auto-clear after a max-size read
    if (rx_rdy_r && (rx_clr_sw || (RX_POP && auto_clear_ready_r && rx_cnt_r == rx_maxp_r))) begin
      if (rx_full_r && dbl) begin
        rx_full_nxt = 1'b0;
        rx_cnt_nxt = rx_cnt2_r;
      end else begin
        rx_rdy_nxt = 1'b0;
        rx_full_nxt = 1'b0;
      end
    end
    if (REQ.valid) begin
      rsp_nxt.valid = 1'b1;
      unique case (REQ.kind)
        TOK_SETUP: begin
          rsp_nxt.hs = HS_ACK;
          data_phase_end_nxt = 1'b0;
          status_nxt = 1'b0;
        end
        TOK_IN: begin
          if (REQ.ep == 2'h0) begin
            if (data_phase_end_r && !ep0_transmit_packet_ready_r)
              rsp_nxt.hs = HS_STALL;
            else if (!ep0_transmit_packet_ready_r)
              rsp_nxt.hs = HS_NAK;
            else begin
              rsp_nxt.hs = HS_ACK;
              rsp_nxt.len = 11'(`EP0_FIFO_BYTES);
              ep0_transmit_packet_ready_nxt = 1'b0;
              ev_nxt[0] = 1'b1;
            end
          end else if (!tx_rdy_r)
            rsp_nxt.hs = HS_NAK;
          else begin
            rsp_nxt.hs = HS_ACK;
            rsp_nxt.len = payload(tx_maxp_r);
            if (!tx_split_r || tx_pkt_r + 5'h01 >= mult(tx_maxp_r)) begin
              rsp_nxt.last = 1'b1;
              tx_rdy_nxt = 1'b0;
              ev_nxt[1] = 1'b1;
            end else
              tx_pkt_nxt = tx_pkt_r + 5'h01;
          end
        end
        TOK_OUT: begin
          if (REQ.ep == 2'h0) begin
            if (status_r && REQ.len != 11'h000)
              rsp_nxt.hs = HS_STALL;
            else if (data_phase_end_r && outdone_r)
              rsp_nxt.hs = HS_STALL;
            else if (REQ.len == 11'h000 && !data_phase_end_r && !status_r) begin
              rsp_nxt.hs = HS_ACK;
              flush_nxt = 1'b1;
              ep0_transmit_packet_ready_nxt = 1'b0;
              setupend_nxt = 1'b1;
              ev_nxt[0] = 1'b1;
            end else begin
              rsp_nxt.hs = HS_ACK;
              outdone_nxt = 1'b1;
              ev_nxt[0] = 1'b1;
            end
          end else if (REQ.len > payload(rx_maxp_r)) begin
            rsp_nxt.hs = HS_STALL;
            ev_nxt[2] = 1'b1;
          end else if (rx_full_r || (rx_rdy_r && !dbl))
            rsp_nxt.hs = HS_NAK;
          else if (comb_r) begin
            rsp_nxt.hs = HS_ACK;
            if (comb_pkt_r + 5'h01 >= mult(rx_maxp_r) || REQ.len < payload(rx_maxp_r)) begin
              rx_rdy_nxt = 1'b1;
              rx_cnt_nxt = comb_len_r + 16'(REQ.len);
              comb_pkt_nxt = 5'h00;
              comb_len_nxt = 16'h0000;
              ev_nxt[2] = 1'b1;
            end else begin
              comb_pkt_nxt = comb_pkt_r + 5'h01;
              comb_len_nxt = comb_len_r + 16'(REQ.len);
            end
          end else begin
            rsp_nxt.hs = HS_ACK;
            ev_nxt[2] = 1'b1;
            if (!rx_rdy_nxt) begin
              rx_rdy_nxt = 1'b1;
              rx_full_nxt = !dbl;
              rx_cnt_nxt = 16'(REQ.len);
            end else begin
              rx_full_nxt = 1'b1;
              rx_cnt2_nxt = 16'(REQ.len);
            end
          end
        end
        default: rsp_nxt.hs = HS_NAK;
      endcase
      if (REQ.ep == 2'h0 && rsp_nxt.hs == HS_STALL)
        ev_nxt[0] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      tx_maxp_r <= `RST_MAXP;
      rx_maxp_r <= `RST_MAXP;
      rx_fifo_r <= `RST_RX_FIFO_SIZE;
      tx_rdy_r <= 1'b0;
      tx_split_r <= 1'b0;
      tx_pkt_r <= 5'h00;
      rx_rdy_r <= 1'b0;
      rx_full_r <= 1'b0;
      auto_clear_ready_r <= 1'b0;
      comb_r <= 1'b0;
      dbuf_dis_r <= `RST_DBUF_DIS;
      rx_cnt_r <= 16'h0000;
      rx_cnt2_r <= 16'h0000;
      comb_len_r <= 16'h0000;
      comb_pkt_r <= 5'h00;
      data_phase_end_r <= 1'b0;
      setupend_r <= 1'b0;
      status_r <= 1'b0;
      ep0_transmit_packet_ready_r <= 1'b0;
      outdone_r <= 1'b0;
      ev_r <= 3'h0;
      rsp_r <= '{valid: 1'b0, hs: HS_NONE, len: 11'h000, last: 1'b0};
      flush_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= '0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      rdy_r <= 3'h7;
      bv_r <= 1'b0;
      bresp_r <= 2'h0;
      rv_r <= 1'b0;
      rd_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      tx_maxp_r <= tx_maxp_nxt;
      rx_maxp_r <= rx_maxp_nxt;
      rx_fifo_r <= rx_fifo_nxt;
      tx_rdy_r <= tx_rdy_nxt;
      tx_split_r <= tx_split_nxt;
      tx_pkt_r <= tx_pkt_nxt;
      rx_rdy_r <= rx_rdy_nxt;
      rx_full_r <= rx_full_nxt;
      auto_clear_ready_r <= auto_clear_ready_nxt;
      comb_r <= comb_nxt;
      dbuf_dis_r <= dbuf_dis_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_cnt2_r <= rx_cnt2_nxt;
      comb_len_r <= comb_len_nxt;
      comb_pkt_r <= comb_pkt_nxt;
      data_phase_end_r <= data_phase_end_nxt;
      setupend_r <= setupend_nxt;
      status_r <= status_nxt;
      ep0_transmit_packet_ready_r <= ep0_transmit_packet_ready_nxt;
      outdone_r <= outdone_nxt;
      ev_r <= ev_nxt;
      rsp_r <= rsp_nxt;
      flush_r <= flush_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      rdy_r <= rdy_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Ready flags registered so no output passes through gates
  assign AWREADY = rdy_r[2];
  assign WREADY = rdy_r[1];
  assign ARREADY = rdy_r[0];
  assign BVALID = bv_r;
  assign BRESP = bresp_r;
  assign RVALID = rv_r;
  assign RDATA = rd_r;
  assign RRESP = rresp_r;
  assign RSP = rsp_r;
  assign EP0_FLUSH = flush_r;
  assign EP_EVENT = ev_r;

  sequence s_out_busy;
    REQ.valid && REQ.kind == TOK_OUT && REQ.ep != 2'h0 && rx_full_r
      && REQ.len <= payload(rx_maxp_r);
  endsequence
  a_nak_when_full: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_out_busy |=> RSP.valid && RSP.hs == HS_NAK) else $error("full endpoint not NAKed");
  a_oversize_stall: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    REQ.valid && REQ.kind == TOK_OUT && REQ.ep != 2'h0 && REQ.len > payload(rx_maxp_r)
    |=> RSP.hs == HS_STALL) else $error("oversize OUT not stalled");
  a_single_full: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(rx_rdy_r) && !$past(dbl) && !$past(comb_r) |-> rx_full_r)
    else $error("single buffer ready without full");
  a_double_first: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(rx_rdy_r) && $past(dbl) |-> !rx_full_r) else $error("full on first packet");
  a_full_to_ready: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $fell(rx_full_r) && $past(rx_rdy_r) && $past(dbl) && !$past(REQ.valid) |-> rx_rdy_r)
    else $error("second packet lost");
  a_in_nak: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    REQ.valid && REQ.kind == TOK_IN && REQ.ep != 2'h0 && !tx_rdy_r |=> RSP.hs == HS_NAK)
    else $error("unready IN not NAKed");
  a_status_stall: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    REQ.valid && REQ.kind == TOK_OUT && REQ.ep == 2'h0 && status_r && REQ.len != 11'h000
    |=> RSP.hs == HS_STALL) else $error("status data not stalled");
  a_tx_done: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    RSP.valid && RSP.last |-> !tx_rdy_r && EP_EVENT[1]) else $error("tx not completed");
endmodule // usb_ep_buffer

//--- verification/usb_host_model.sv
// Behavioural host controller: issues tokens and collects the device handshakes
`timescale 1ns/10ps
module usb_host_model
  import usb_ep_pkg::*;
(
  // Clock
  input wire logic clk,
  // Token out, handshake back
  output usb_req_t req,
  input wire usb_rsp_t rsp
);
  initial req = '0;
  // One token at a time; no second try after a NAK, so retries are up to the caller
  task automatic token(input token_t k, input logic [1:0] ep, input logic [10:0] n,
      output usb_rsp_t r);
    int w;
    @(posedge clk);
    req <= '{valid: 1'b1, kind: k, ep: ep, len: n};
    @(posedge clk);
    // Released lines carry junk, not the last token
    req <= '{valid: 1'b0, kind: TOK_SETUP, ep: ~ep, len: ~n};
    r = '0;
    // No answer reads as no handshake, never as a NAK
    r.hs = HS_NONE;
    for (w = 0; w < 8 && r.valid !== 1'b1; w++) begin
      @(negedge clk);
      if (rsp.valid === 1'b1) r = rsp;
    end
  endtask
endmodule // usb_host_model

//--- verification/tb_top.sv
// Self-checking bench for the endpoint buffering block
`timescale 1ns/10ps
`include "usb_ep_consts.svh"
module tb_top;
  import usb_ep_pkg::*;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic rx_pop = 1'b0, flush_seen = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ep0_flush;
  logic [1:0] bresp, rresp, bres;
  logic [31:0] rdata, d;
  logic [2:0] ep_event;
  usb_req_t req;
  usb_rsp_t rsp, r;
  int failures = 0, samples_checked = 0, cycles = 0;

  always #12.5 clk = ~clk;

  usb_ep_buffer #(.ADDR_W(8)) i_dut (
    .CLK_SYS(clk), .RSTN(rstn),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .REQ(req), .RSP(rsp), .RX_POP(rx_pop), .EP0_FLUSH(ep0_flush), .EP_EVENT(ep_event)
  );
  usb_host_model i_host (.clk(clk), .req(req), .rsp(rsp));

  always @(posedge clk) begin
    if (ep0_flush === 1'b1) flush_seen <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    for (n = 0; n < 50 && !bh; n++) begin
      @(negedge clk);
      ah = (awvalid & awready) === 1'b1;
      wh = (wvalid & wready) === 1'b1;
      bh = (bvalid & bready) === 1'b1;
      if (bh) bres = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) failures++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ah, rh;
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    for (n = 0; n < 50 && !rh; n++) begin
      @(negedge clk);
      ah = (arvalid & arready) === 1'b1;
      rh = (rvalid & rready) === 1'b1;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) failures++;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [1:0] rs;
    axi_rd(a, d, rs);
    check(d & m, e);
  endtask

  task automatic pop();
    @(posedge clk);
    rx_pop <= 1'b1;
    @(posedge clk);
    rx_pop <= 1'b0;
  endtask

  task automatic t_reset();
    logic [1:0] rs;
    rd_chk(`OFS_RX_DBUF_DIS, 32'h00000001, 32'h00000001);
    rd_chk(`OFS_RX_MAXP, 32'h0000FFFF, 32'h00000040);
    rd_chk(`OFS_RX_FIFO_SIZE, 32'h0000FFFF, 32'h00000040);
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000000);
    axi_rd(8'h3C, d, rs);
    check(32'(rs), 32'h00000002);
    axi_wr(8'h3C, 32'h00000000);
    check(32'(bres), 32'h00000002);
    $display("t_reset done");
  endtask

  task automatic t_single();
    // Max packet equals FIFO size, so only one packet fits
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    check(32'(r.hs), 32'(HS_ACK));
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000003);
    check(32'(ep_event[2]), 32'h00000001);
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    check(32'(r.hs), 32'(HS_NAK));
    axi_wr(`OFS_RX_CTRL, 32'h00000000);
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000000);
    i_host.token(TOK_OUT, 2'h1, 11'h041, r);
    check(32'(r.hs), 32'(HS_STALL));
    axi_wr(`OFS_RX_MAXP, 32'h00000008);
    axi_wr(`OFS_RX_CTRL, 32'h00000004);
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    pop();
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000000);
    i_host.token(TOK_OUT, 2'h1, 11'h004, r);
    pop();
    rd_chk(`OFS_RX_CTRL, 32'h00000001, 32'h00000001);
    axi_wr(`OFS_RX_CTRL, 32'h00000000);
    axi_wr(`OFS_RX_MAXP, 32'h00000040);
    $display("t_single done");
  endtask

  task automatic t_double();
    axi_wr(`OFS_RX_DBUF_DIS, 32'h00000000);
    axi_wr(`OFS_RX_FIFO_SIZE, 32'h00000080);
    i_host.token(TOK_OUT, 2'h1, 11'h040, r);
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000001);
    i_host.token(TOK_OUT, 2'h1, 11'h040, r);
    check(32'(r.hs), 32'(HS_ACK));
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000003);
    axi_wr(`OFS_RX_CTRL, 32'h00000000);
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000001);
    axi_wr(`OFS_RX_CTRL, 32'h00000000);
    rd_chk(`OFS_RX_CTRL, 32'h00000003, 32'h00000000);
    axi_wr(`OFS_RX_DBUF_DIS, 32'h00000001);
    $display("t_double done");
  endtask

  task automatic t_combine();
    // Multiplier 2, payload 8; the FIFO holds the whole block
    axi_wr(`OFS_RX_MAXP, 32'h00001008);
    axi_wr(`OFS_RX_CTRL, 32'h00000008);
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    rd_chk(`OFS_RX_CTRL, 32'h00000001, 32'h00000000);
    i_host.token(TOK_OUT, 2'h1, 11'h004, r);
    rd_chk(`OFS_RX_CTRL, 32'h00000001, 32'h00000001);
    rd_chk(`OFS_RX_COUNT, 32'h0000FFFF, 32'h0000000C);
    // A lone short packet ends the block early
    axi_wr(`OFS_RX_CTRL, 32'h00000008);
    i_host.token(TOK_OUT, 2'h1, 11'h004, r);
    rd_chk(`OFS_RX_CTRL, 32'h00000001, 32'h00000001);
    rd_chk(`OFS_RX_COUNT, 32'h0000FFFF, 32'h00000004);
    axi_wr(`OFS_RX_CTRL, 32'h00000008);
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    i_host.token(TOK_OUT, 2'h1, 11'h008, r);
    rd_chk(`OFS_RX_CTRL, 32'h00000001, 32'h00000001);
    rd_chk(`OFS_RX_COUNT, 32'h0000FFFF, 32'h00000010);
    axi_wr(`OFS_RX_CTRL, 32'h00000000);
    $display("t_combine done");
  endtask

  task automatic t_split();
    axi_wr(`OFS_EVENTS, 32'h00000007);
    i_host.token(TOK_IN, 2'h1, 11'h000, r);
    check(32'(r.hs), 32'(HS_NAK));
    axi_wr(`OFS_TX_MAXP, 32'h00001008);
    axi_wr(`OFS_TX_CTRL, 32'h00000003);
    i_host.token(TOK_IN, 2'h1, 11'h000, r);
    check({21'h0, r.len}, 32'h00000008);
    check(32'(r.last), 32'h00000000);
    i_host.token(TOK_IN, 2'h1, 11'h000, r);
    check({21'h0, r.len}, 32'h00000008);
    check(32'(r.last), 32'h00000001);
    rd_chk(`OFS_TX_CTRL, 32'h00000001, 32'h00000000);
    check(32'(ep_event[1]), 32'h00000001);
    $display("t_split done");
  endtask

  task automatic t_ep0();
    int n;
    axi_wr(`OFS_EVENTS, 32'h00000007);
    i_host.token(TOK_OUT, 2'h0, 11'h008, r);
    check(32'(r.hs), 32'(HS_ACK));
    check(32'(ep_event[0]), 32'h00000001);
    // Last OUT packet unloaded, then data end set; one more OUT overruns
    axi_wr(`OFS_EP0_CTRL, 32'h00000011);
    i_host.token(TOK_OUT, 2'h0, 11'h008, r);
    check(32'(r.hs), 32'(HS_STALL));
    i_host.token(TOK_IN, 2'h0, 11'h000, r);
    check(32'(r.hs), 32'(HS_STALL));
    axi_wr(`OFS_EP0_CTRL, 32'h00000004);
    axi_wr(`OFS_EVENTS, 32'h00000007);
    i_host.token(TOK_OUT, 2'h0, 11'h003, r);
    check(32'(r.hs), 32'(HS_STALL));
    check(32'(ep_event[0]), 32'h00000001);
    // IN data waiting, then the host ends early with an empty OUT
    axi_wr(`OFS_EP0_CTRL, 32'h00000008);
    @(posedge clk);
    flush_seen <= 1'b0;
    i_host.token(TOK_OUT, 2'h0, 11'h000, r);
    for (n = 0; n < 8 && flush_seen !== 1'b1; n++) @(posedge clk);
    check(32'(flush_seen), 32'h00000001);
    rd_chk(`OFS_EP0_CTRL, 32'h0000000A, 32'h00000002);
    $display("t_ep0 done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_double();
    t_combine();
    t_split();
    t_ep0();
    give_verdict();
  end
endmodule // tb_top
